// *** common/sdf_pkg.sv ***
package sdf_pkg;
    // slot count and index width
    localparam int SLOT_COUNT = 16;
    localparam int SLOT_IDX_W = 4;
    // serial link word and buffer shape
    localparam int LINK_WORD_W = 16;
    localparam int LINK_FIFO_DEPTH = 16;
    localparam logic [3:0] LINK_LAST_BIT = 4'hF;
    // reset values of the configuration state
    localparam logic RETIME_RST = 1'b1;
    localparam logic [15:0] BYPASS_RST = 16'h0000;
    localparam logic [3:0] LINK_SEL_RST = 4'h0;
    // index value meaning no further slot in the sequence
    localparam logic [4:0] SLOT_NONE = 5'h10;

    // trigger and sync lines from the trigger board
    typedef struct packed {
        logic sync;            // sync line
        logic trigger_line_one;
        logic trigger_line_two;
    } sdf_tsig_t;

    // status line command
    typedef struct packed {
        logic broadcast;       // drive every slot
        logic value;           // level to drive
        logic [3:0] slot;      // single slot when not broadcast
    } sdf_status_cmd_t;

    // token ring states, gray along idle-hold-done
    typedef enum logic [1:0] {
        TOK_IDLE = 2'b00,
        TOK_HOLD = 2'b01,
        TOK_DONE = 2'b11
    } sdf_tok_state_t;
endpackage : sdf_pkg

// *** design/sdf_fifo.sv ***
`timescale 1ns/1ps
module sdf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,              // system clock
    input wire logic rst,                  // async reset, high
    input wire logic in_valid,             // write request
    output logic in_ready,                 // room available
    input wire logic [WIDTH-1:0] in_data,  // write data
    output logic out_valid,                // data available
    input wire logic out_ready,            // reader takes word
    output logic [WIDTH-1:0] out_data      // read data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];         // storage
    logic [AW:0] wr_ptr, rd_ptr;           // pointers with wrap bit
    logic [AW:0] next_wr_ptr, next_rd_ptr;
    logic push, pop;

    // full when pointers differ only in wrap bit
    always_comb begin
        in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
        out_valid = (wr_ptr != rd_ptr);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
        out_data = mem[rd_ptr[AW-1:0]];
    end

    // pointer registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage write, no reset needed
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule : sdf_fifo

// *** design/sdf_distribution_module.sv ***
`timescale 1ns/1ps
module sdf_distribution_module (
    input wire logic sys_clk,                        // 40 MHz system clock
    input wire logic rst,                            // async reset, high
    input wire logic board_clock_one,                // first clock from trigger board
    input wire logic board_clock_two,                // second clock from trigger board
    input wire logic panel_clock,                    // front-panel clock input
    input wire logic clock_one_use_panel,            // first fanout takes panel clock
    input wire logic clock_two_use_panel,            // second fanout takes panel clock
    output logic [15:0] fanout_clock_one,            // first clock to slots
    output logic [15:0] fanout_clock_two,            // second clock to slots
    input wire sdf_pkg::sdf_tsig_t board_tsig,       // sync and triggers from board
    output sdf_pkg::sdf_tsig_t [15:0] slot_tsig,     // sync and triggers to slots
    input wire logic retime_wr,                      // load retime choice
    input wire logic retime_in,                      // 1 retimed, 0 pass-through
    output logic retime_mode,                        // held retime choice
    input wire logic board_token,                    // token from trigger board
    input wire logic [15:0] token_return,            // token handed back per slot
    output logic [15:0] token_grant,                 // token given per slot
    output logic token_to_board,                     // ring finished, one cycle
    input wire logic bypass_wr,                      // load bypass pattern
    input wire logic [15:0] bypass_in,               // 1 skips that slot
    output logic [15:0] bypass_mask,                 // held bypass pattern
    input wire logic [15:0] trigger_request,         // trigger per slot
    output logic panel_trigger_out,                  // ORed triggers
    input wire logic [15:0] buffer_full,             // buffer full per slot
    output logic [15:0] board_buffer_full,           // per-slot copy to board
    output logic board_busy,                         // ORed buffer full
    input wire sdf_pkg::sdf_status_cmd_t status_cmd, // status line command
    output logic [15:0] status_line_out,             // status line per slot
    input wire logic [15:0] payload_serial_data_link, // serial data per slot
    input wire logic [3:0] link_sel,                 // slot whose link is captured
    output logic [15:0] link_data,                   // captured word
    output logic link_valid,                         // word available
    input wire logic link_ready,                     // board takes word
    output logic link_overrun,                       // bits lost, sticky
    input wire logic link_overrun_clr                // clear overrun
);
    import sdf_pkg::*;

    localparam int PIN_W = 4*SLOT_COUNT + 4;
    logic [PIN_W-1:0] pin_meta, pin_sync;            // two-stage pin synchroniser
    logic [15:0] ret_s, trq_s, bfl_s, lnk_s;         // synchronised pins
    logic tok_s, tok_d;                              // board token and delayed copy
    logic [15:0] ret_d;                              // delayed token returns
    sdf_tsig_t tsig_s;                               // retimed sync and triggers

    // synchronise the slot and trigger-board signal inputs through two flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {payload_serial_data_link, buffer_full, trigger_request, token_return,
                         board_token, board_tsig};
            pin_sync <= pin_meta;
        end
    end

    // split the synchronised vector
    always_comb begin
        tsig_s = pin_sync[2:0];
        tok_s = pin_sync[3];
        ret_s = pin_sync[19:4];
        trq_s = pin_sync[35:20];
        bfl_s = pin_sync[51:36];
        lnk_s = pin_sync[67:52];
    end

    // clock fanout, each clock chosen on its own
    always_comb begin
        fanout_clock_one = {SLOT_COUNT{clock_one_use_panel ? panel_clock : board_clock_one}};
        fanout_clock_two = {SLOT_COUNT{clock_two_use_panel ? panel_clock : board_clock_two}};
    end

    // sync and triggers, one source to all slots
    always_comb begin
        for (int i = 0; i < SLOT_COUNT; i++) begin
            slot_tsig[i] = retime_mode ? tsig_s : board_tsig;
        end
    end

    // configuration state
    logic next_retime_mode;
    logic [15:0] next_bypass_mask;
    logic [3:0] link_sel_q, next_link_sel;           // captured link slot
    sdf_tok_state_t tok_state, next_tok_state;
    always_comb begin
        next_retime_mode = retime_wr ? retime_in : retime_mode;
        // pattern only changes while no token circulates
        next_bypass_mask = (bypass_wr && tok_state == TOK_IDLE) ? bypass_in : bypass_mask;
        next_link_sel = link_sel;
    end

    // configuration registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            retime_mode <= RETIME_RST;
            bypass_mask <= BYPASS_RST;
            link_sel_q <= LINK_SEL_RST;
        end else begin
            retime_mode <= next_retime_mode;
            bypass_mask <= next_bypass_mask;
            link_sel_q <= next_link_sel;
        end
    end

    // lowest slot at or above start that is not bypassed
    function automatic logic [4:0] find_next(input logic [15:0] skip, input logic [4:0] start);
        logic [4:0] res;
        res = SLOT_NONE;
        for (int i = SLOT_COUNT - 1; i >= 0; i--) begin
            if (5'(i) >= start && !skip[i]) begin
                res = 5'(i);
            end
        end
        return res;
    endfunction : find_next

    // token ring next state
    logic [3:0] cur_slot, next_cur_slot;             // slot holding token
    logic [15:0] next_token_grant;
    logic [4:0] cand;                                // candidate slot
    logic tok_rise;
    logic advance;                                   // token moves this cycle
    logic [15:0] ret_rise;
    always_comb begin
        tok_rise = tok_s && !tok_d;
        ret_rise = ret_s & ~ret_d;
        next_tok_state = tok_state;
        next_cur_slot = cur_slot;
        cand = SLOT_NONE;
        advance = 1'b0;
        case (tok_state)
            TOK_IDLE: begin
                // ring starts only on the board token
                if (tok_rise) begin
                    cand = find_next(bypass_mask, 5'h00);
                    advance = 1'b1;
                end
            end
            TOK_HOLD: begin
                // only the holder's hand-back moves it right; a board token here is ignored
                if (ret_rise[cur_slot]) begin
                    cand = find_next(bypass_mask, {1'b0, cur_slot} + 5'h01);
                    advance = 1'b1;
                end
            end
            default: begin
                next_tok_state = TOK_IDLE;
            end
        endcase
        // no slot left means the ring is finished
        if (advance) begin
            if (cand[4]) begin
                next_tok_state = TOK_DONE;
            end else begin
                next_tok_state = TOK_HOLD;
                next_cur_slot = cand[3:0];
            end
        end
        next_token_grant = (next_tok_state == TOK_HOLD) ? (16'h0001 << next_cur_slot) : 16'h0000;
    end

    // token ring registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tok_state <= TOK_IDLE;
            cur_slot <= 4'h0;
            token_grant <= 16'h0000;
            tok_d <= 1'b0;
            ret_d <= 16'h0000;
        end else begin
            tok_state <= next_tok_state;
            cur_slot <= next_cur_slot;
            token_grant <= next_token_grant;
            tok_d <= tok_s;
            ret_d <= ret_s;
        end
    end

    // last slot done tells the board
    always_comb begin
        token_to_board = (tok_state == TOK_DONE);
    end

    // aggregation and status next values
    logic next_panel_trigger, next_board_busy;
    logic [15:0] next_board_buffer_full, next_status;
    always_comb begin
        next_panel_trigger = |trq_s;
        next_board_busy = |bfl_s;
        next_board_buffer_full = bfl_s;
        if (status_cmd.broadcast) begin
            next_status = {SLOT_COUNT{status_cmd.value}};
        end else begin
            next_status = 16'h0000;
            next_status[status_cmd.slot] = status_cmd.value;
        end
    end

    // aggregation and status registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            panel_trigger_out <= 1'b0;
            board_busy <= 1'b0;
            board_buffer_full <= 16'h0000;
            status_line_out <= 16'h0000;
        end else begin
            panel_trigger_out <= next_panel_trigger;
            board_busy <= next_board_busy;
            board_buffer_full <= next_board_buffer_full;
            status_line_out <= next_status;
        end
    end

    // serial link deserialiser next values
    logic [15:0] shift, next_shift;                  // bits gathered, first bit in msb
    logic [3:0] bit_cnt, next_bit_cnt;
    logic word_full, next_word_full;                 // word waits for buffer
    logic next_overrun, fifo_in_ready;
    always_comb begin
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_word_full = word_full;
        next_overrun = link_overrun && !link_overrun_clr;
        if (word_full && fifo_in_ready) begin
            next_word_full = 1'b0;
        end
        if (!word_full || fifo_in_ready) begin
            next_shift = {shift[14:0], lnk_s[link_sel_q]};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == LINK_LAST_BIT) begin
                next_word_full = 1'b1;
            end
        end else begin
            next_overrun = 1'b1;                     // set beats clear
        end
    end

    // serial link registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift <= 16'h0000;
            bit_cnt <= 4'h0;
            word_full <= 1'b0;
            link_overrun <= 1'b0;
        end else begin
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            word_full <= next_word_full;
            link_overrun <= next_overrun;
        end
    end

    // sixteen-word buffer toward the trigger board
    sdf_fifo #(.WIDTH(LINK_WORD_W), .DEPTH(LINK_FIFO_DEPTH)) u_link_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(word_full),
        .in_ready(fifo_in_ready),
        .in_data(shift),
        .out_valid(link_valid),
        .out_ready(link_ready),
        .out_data(link_data)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_returned;
        tok_state == TOK_HOLD && ret_rise[cur_slot];
    endsequence

    property p_grant_onehot;
        $onehot0(token_grant);
    endproperty
    a_grant_onehot: assert property (p_grant_onehot) else $error("more than one grant");
    property p_idle_no_grant;
        tok_state != TOK_HOLD |-> token_grant == 16'h0000;
    endproperty
    a_idle_no_grant: assert property (p_idle_no_grant) else $error("grant outside hold");
    property p_pass_right;
        s_returned ##1 tok_state == TOK_HOLD |-> cur_slot > $past(cur_slot);
    endproperty
    a_pass_right: assert property (p_pass_right) else $error("token did not move right");
    property p_return_moves;
        s_returned |=> token_grant != $past(token_grant);
    endproperty
    a_return_moves: assert property (p_return_moves) else $error("token not passed");
    property p_bypass_hold;
        tok_state != TOK_IDLE |=> bypass_mask == $past(bypass_mask);
    endproperty
    a_bypass_hold: assert property (p_bypass_hold) else $error("bypass changed while busy");
    property p_retime_out;
        retime_mode |-> slot_tsig[SLOT_COUNT-1] == $past(board_tsig, 2);
    endproperty
    a_retime_out: assert property (p_retime_out) else $error("retimed lines wrong");
    property p_pass_out;
        !retime_mode |-> slot_tsig[0] == board_tsig;
    endproperty
    a_pass_out: assert property (p_pass_out) else $error("pass-through lines wrong");
    property p_busy_or;
        ##3 1'b1 |-> board_busy == (|$past(buffer_full, 3));
    endproperty
    a_busy_or: assert property (p_busy_or) else $error("busy OR wrong");
    property p_trig_or;
        ##3 1'b1 |-> panel_trigger_out == (|$past(trigger_request, 3));
    endproperty
    a_trig_or: assert property (p_trig_or) else $error("trigger OR wrong");
    property p_status_bcast;
        status_cmd.broadcast |=> status_line_out == {SLOT_COUNT{$past(status_cmd.value)}};
    endproperty
    a_status_bcast: assert property (p_status_bcast) else $error("broadcast status wrong");
    property p_retime_keep;
        !retime_wr |=> retime_mode == $past(retime_mode);
    endproperty
    a_retime_keep: assert property (p_retime_keep) else $error("retime choice drifted");
endmodule : sdf_distribution_module

// *** verification/sdf_payload_model.sv ***
`timescale 1ns/1ps
// sixteen payload slots: buffers that drain to the bus only under the token
module sdf_payload_model #(
    parameter int CAP = 2 // buffer depth in words
) (
    input wire logic sys_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic [15:0] fill, // one word arrives per slot
    input wire logic [15:0] token_grant, // token held per slot
    output logic [15:0] token_return, // token handed back
    output logic [15:0] buffer_full // buffer full per slot
);
    int cnt [16]; // words held
    int hold [16]; // cycles left before hand-back
    logic [15:0] done = 16'h0000; // hand-back raised
    // flags follow the counts; hand-back stays up until the grant drops
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            buffer_full[i] = (cnt[i] == CAP);
            token_return[i] = done[i] & token_grant[i];
        end
    end
    // even slots answer promptly, odd slots dawdle before handing back
    always @(posedge sys_clk or posedge rst) begin
        for (int i = 0; i < 16; i++) begin
            if (rst) begin
                cnt[i] <= 0;
                done[i] <= 1'h0;
                hold[i] <= 0;
            end else if (!token_grant[i]) begin
                done[i] <= 1'h0;
                hold[i] <= (i % 2) * 6;
                if (fill[i] && cnt[i] < CAP) cnt[i] <= cnt[i] + 1;
            end else if (cnt[i] > 0) begin
                cnt[i] <= cnt[i] - 1; // bus writes only under the token
            end else if (hold[i] > 0) begin
                hold[i] <= hold[i] - 1;
            end else begin
                done[i] <= 1'h1;
            end
        end
    end
endmodule : sdf_payload_model

// *** verification/test_crate_signal_fanout_and_token_ring.sv ***
`timescale 1ns/1ps
// bench for fanout, aggregation, status, token ring and link capture
module test_crate_signal_fanout_and_token_ring;
    import sdf_pkg::*;
    logic sys_clk = 1'h0; // 40 MHz clock
    logic rst = 1'h1; // async reset, high
    logic board_clock_one = 1'h0, board_clock_two = 1'h0, panel_clock = 1'h0; // clock sources
    logic clock_one_use_panel = 1'h0, clock_two_use_panel = 1'h0; // panel selects
    logic [15:0] fanout_clock_one, fanout_clock_two; // clocks to slots
    sdf_tsig_t board_tsig = 3'h0; // sync and triggers in
    sdf_tsig_t [15:0] slot_tsig; // sync and triggers out
    logic retime_wr = 1'h0, retime_in = 1'h0, retime_mode; // retime choice
    logic board_token = 1'h0, token_to_board, bypass_wr = 1'h0; // ring control
    logic [15:0] token_return, token_grant, bypass_in = 16'h0000, bypass_mask; // ring per slot
    logic [15:0] trigger_request = 16'h0000, buffer_full, board_buffer_full, fill = 16'h0000; // aggregation
    logic panel_trigger_out, board_busy; // combined outputs
    sdf_status_cmd_t status_cmd = 6'h00; // status command
    logic [15:0] status_line_out, link_pins = 16'h0020, link_data; // status and link
    logic [3:0] link_sel = 4'h5; // captured slot
    logic link_valid, link_ready = 1'h1, link_overrun, link_overrun_clr = 1'h0; // link handshake
    int miscompares = 0; // mismatches
    int checks = 0; // comparisons
    int cyc = 0; // cycles run
    int n; // general count
    logic [15:0] last_grant = 16'h0000; // grant seen last cycle
    logic [15:0] order_q [$]; // grants in order of arrival
    logic [15:0] full_exp = 16'hFFFF; // slots still holding full buffers
    logic [15:0] pats [2] = '{16'h0C21, 16'h8001}; // bypass patterns, both skip the first slot, only the second also skips the last
    sdf_distribution_module DUT (
        .sys_clk, .rst, .board_clock_one, .board_clock_two, .panel_clock, .clock_one_use_panel,
        .clock_two_use_panel, .fanout_clock_one, .fanout_clock_two, .board_tsig, .slot_tsig, .retime_wr,
        .retime_in, .retime_mode, .board_token, .token_return, .token_grant, .token_to_board, .bypass_wr,
        .bypass_in, .bypass_mask, .trigger_request, .panel_trigger_out, .buffer_full, .board_buffer_full,
        .board_busy, .status_cmd, .status_line_out, .payload_serial_data_link(link_pins), .link_sel,
        .link_data, .link_valid, .link_ready, .link_overrun, .link_overrun_clr
    );
    sdf_payload_model #(.CAP(2)) slots (.sys_clk, .rst, .fill, .token_grant, .token_return, .buffer_full);
    always #12.5 sys_clk = ~sys_clk;
    // count one comparison and report a mismatch
    task automatic check_val(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : tick
    // one-cycle load strobe for the retime choice or the bypass pattern
    task automatic load_cfg(input logic is_bypass, input logic [15:0] v);
        retime_in = v[0];
        bypass_in = v;
        retime_wr = !is_bypass;
        bypass_wr = is_bypass;
        tick(1);
        retime_wr = 1'h0;
        bypass_wr = 1'h0;
        tick(1);
    endtask : load_cfg
    // wait for a captured word under a bound
    task automatic wait_word();
        for (int k = 0; k < 40 && link_valid !== 1'h1; k++) begin
            tick(1);
        end
    endtask : wait_word
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            give_verdict();
        end
    end
    // record each new holder of the token
    always @(negedge sys_clk) begin
        if (token_grant !== last_grant && token_grant !== 16'h0000) begin
            order_q.push_back(token_grant);
        end
        last_grant <= token_grant;
    end
    // main sequence
    initial begin
        tick(3);
        rst = 1'h0;
        check_val("retime_mode", 1, retime_mode);
        check_val("reset outputs", 0, {bypass_mask, status_line_out, link_overrun});
        tick(10);
        check_val("token_grant", 0, {token_grant, token_to_board});
        $display("test reset finished");
        for (int k = 0; k < 32; k++) begin
            {clock_one_use_panel, clock_two_use_panel, board_clock_one, board_clock_two, panel_clock} = k[4:0];
            tick(1);
            check_val("fanout_clock_one", {16{clock_one_use_panel ? panel_clock : board_clock_one}},
                fanout_clock_one);
            check_val("fanout_clock_two", {16{clock_two_use_panel ? panel_clock : board_clock_two}},
                fanout_clock_two);
        end
        $display("test clocks finished");
        load_cfg(1'h0, 16'h0000);
        check_val("retime_mode", 0, retime_mode);
        for (int k = 0; k < 8; k++) begin
            board_tsig = k[2:0];
            tick(1);
            check_val("slot_tsig pass", {16{k[2:0]}}, slot_tsig);
        end
        load_cfg(1'h0, 16'h0001);
        board_tsig = 3'h2;
        tick(1);
        check_val("slot_tsig early", {16{3'h7}}, slot_tsig);
        tick(1);
        check_val("slot_tsig retimed", {16{3'h2}}, slot_tsig);
        $display("test sync and triggers finished");
        for (int i = 0; i < 16; i++) begin
            trigger_request = 16'h0001 << i;
            fill = 16'h0001 << i;
            tick(2);
            fill = 16'h0000;
            tick(4);
            check_val("panel_trigger_out", 1, panel_trigger_out);
            check_val("board_buffer_full", (17'h00002 << i) - 1, board_buffer_full);
            check_val("board_busy", 1, board_busy);
        end
        trigger_request = 16'h0000;
        tick(3);
        check_val("panel_trigger_out", 0, panel_trigger_out);
        $display("test aggregation finished");
        for (int r = 0; r < 2; r++) begin
            load_cfg(1'h1, pats[r]);
            check_val("bypass_mask", pats[r], bypass_mask);
            order_q.delete();
            board_token = 1'h1;
            for (n = 0; n < 20 && token_grant === 16'h0000; n++) begin
                tick(1);
            end
            load_cfg(1'h1, 16'hFFFF);
            check_val("bypass_mask busy", pats[r], bypass_mask);
            for (n = 0; n < 1000 && token_to_board !== 1'h1; n++) begin
                tick(1);
            end
            board_token = 1'h0;
            check_val("token_to_board", 1, token_to_board);
            tick(1);
            check_val("ring end", 0, {token_grant, token_to_board});
            check_val("grant count", 16 - $countones(pats[r]), order_q.size());
            n = 0;
            for (int i = 0; i < 16; i++) begin
                if (!pats[r][i]) begin
                    check_val("grant order", 16'h0001 << i, order_q[n]);
                    n++;
                end
            end
            full_exp = full_exp & pats[r];
            tick(4);
            check_val("board_buffer_full", full_exp, board_buffer_full);
            check_val("board_busy", |full_exp, board_busy);
        end
        check_val("retime_mode", 1, retime_mode);
        $display("test token ring finished");
        for (int i = 0; i < 18; i++) begin
            status_cmd = (i < 16) ? {1'h0, 1'h1, i[3:0]} : {1'h1, i[0], 4'h5};
            tick(1);
            check_val("status_line_out", (i < 16) ? 16'h0001 << i : {16{i[0]}}, status_line_out);
        end
        $display("test status finished");
        wait_word();
        check_val("link_data", 16'hFFFF, link_data);
        link_ready = 1'h0;
        tick(400);
        check_val("link_overrun", 2'h3, {link_overrun, link_valid});
        link_ready = 1'h1;
        n = 0;
        repeat (40) begin
            n += (link_valid === 1'h1);
            tick(1);
        end
        check_val("words buffered", 1, n >= 16);
        link_overrun_clr = 1'h1;
        tick(1);
        link_overrun_clr = 1'h0;
        tick(1);
        check_val("link_overrun", 0, link_overrun);
        link_sel = 4'h6;
        tick(40);
        wait_word();
        check_val("link_data", 16'h0000, link_data);
        $display("test link finished");
        give_verdict();
    end
endmodule : test_crate_signal_fanout_and_token_ring
